// ==== rtl/ccs_pkg.sv ====
// package: constants for the configuration check and start-up sequencer
`default_nettype none
package ccs_pkg;
   // register offsets (word addresses on the plain port)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_PHASE = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_CRC = 4'h3;
   localparam logic [3:0] ADDR_IDCODE = 4'h4;
   // control field positions
   localparam int CTRL_CRC_EN = 0;
   localparam int CTRL_ERRPIN_EN = 1;
   localparam int CTRL_ENCRYPT = 2;
   localparam int CTRL_MASTER = 3;
   localparam int CTRL_FLASH = 4;
   localparam int CTRL_ASYNC_RD = 5;
   localparam int CTRL_LOCK_WAIT = 6;
   localparam int CTRL_MATCH_WAIT = 7;
   localparam logic [7:0] CTRL_RESET = 8'h0B;
   // phase field positions, three bits each
   localparam int PH_LOCK = 0;
   localparam int PH_MATCH = 3;
   localparam int PH_GWE = 6;
   localparam int PH_GTS = 9;
   localparam int PH_DONE = 12;
   localparam logic [14:0] PHASE_RESET = {3'h4, 3'h5, 3'h6, 3'h1, 3'h1};
   localparam logic [2:0] PHASE_LAST = 3'h7;
   // status field positions
   localparam int ST_SYNC = 0;
   localparam int ST_ID_OK = 1;
   localparam int ST_CRC_ERR = 2;
   localparam int ST_ID_ERR = 3;
   localparam int ST_SEC_ERR = 4;
   localparam int ST_FALLBACK = 5;
   localparam int ST_DEAD = 6;
   localparam int ST_RELEASED = 7;
   localparam int ST_EOS = 8;
   localparam int ST_PHASE = 9;
   // stream commands on cmd_code
   localparam logic [2:0] CMD_SYNC = 3'h1;
   localparam logic [2:0] CMD_IDCHK = 3'h2;
   localparam logic [2:0] CMD_FRAME = 3'h3;
   localparam logic [2:0] CMD_CRCCHK = 3'h4;
   localparam logic [2:0] CMD_START = 3'h5;
   localparam logic [2:0] CMD_DESYNC = 3'h6;
   localparam logic [2:0] CMD_WRAP = 3'h7;
   // crc polynomial, reflected, and seed
   localparam logic [31:0] CRC_POLY = 32'h82F63B78;
   localparam logic [31:0] CRC_SEED = 32'h00000000;
   // identification fields: values arbitrary
   localparam logic [3:0] ID_VERSION = 4'h1;
   localparam logic [15:0] ID_DEVICE = 16'h1234;
   localparam logic [10:0] ID_COMPANY = 11'h055;
endpackage
`default_nettype wire

// ==== rtl/ccs_top.sv ====
// config check and start-up sequencer with plain register port
`default_nettype none
// ==========================================================
// Overview of operation
// - no frames loaded before identity check passes
// - identity failure starts fallback reconfiguration
// - id register: version, device, company, one
// - crc accumulates over every loaded word
// - 32-bit crc compared on check command
// - crc mismatch drives error pin, aborts
// - crc check, error pin separately disableable
// - encrypted stream skips crc, security error
// - master mode crc error tries fallback
// - flash fallback failure dead until program
// - lost sync ignores later commands until the next sync
// - master mode async flash address wrap triggers fallback
// - start command runs eight phase sequencer
// - events programmable into phases zero to seven
// - end of start-up always phase seven
// - defaults done four, tristate five, write six
// - stall on lock or match waits
// - stall after release until pin reads high
// - status shows own release of completion pin
// - tristate disables io, write enable state
// - write enable synchronous to config clock
// - error pin open drain active low
module ccs_top
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic cfg_clk_in,
   input wire logic cmd_valid_in,
   input wire logic [2:0] cmd_code_in,
   input wire logic [31:0] cmd_data_in,
   input wire logic auth_fail_in,
   input wire logic clock_gen_locked_in,
   input wire logic impedance_match_in,
   input wire logic done_pin_in,
   input wire logic program_pulse_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic done_pin_out,
   output logic done_pin_oe_n_out,
   output logic error_pin_out,
   output logic error_pin_oe_n_out,
   output logic global_write_enable_out,
   output logic global_tristate_out,
   output logic end_of_startup_out,
   output logic fallback_out,
   output logic frame_we_out
);
   // ==========================================================
   // state
   // loader states kept local so the names need no package prefix
   typedef enum logic [2:0] {LD_IDLE, LD_SYNCED, LD_LOAD, LD_STARTUP, LD_DONE, LD_ABORT,
                             LD_DEAD} ccs_ld_t;
   typedef struct packed {
      logic [1:0] clk_sync;
      logic clk_prev;
      logic [1:0] val_sync;
      logic [1:0] auth_sync;
      logic [1:0] lock_sync;
      logic [1:0] match_sync;
      logic [1:0] done_sync;
      logic [1:0] prog_sync;
      logic [2:0] code_m;
      logic [31:0] data_m;
      logic [2:0] code;
      logic [31:0] data;
      ccs_ld_t ld;
      logic [2:0] phase;
      logic [31:0] crc;
      logic [7:0] ctrl;
      logic [14:0] phsel;
      logic id_ok;
      logic crc_err;
      logic id_err;
      logic sec_err;
      logic fb_tried;
      logic released;
      logic global_write_enable;
      logic global_tristate;
      logic end_of_startup;
      logic err_drive;
      logic fallback;
      logic frame_we;
      logic [31:0] rdata;
   } ccs_state_t;

   ccs_state_t st_r;
   ccs_state_t st_nxt;
   logic rise;

   // ==========================================================
   // functions
   function automatic logic [31:0] ccs_crc_step(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] x;
      x = c ^ d;
      for (int i = 0; i < 32; i++)
      begin
         x = x[0] ? ((x >> 1) ^ ccs_pkg::CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   function automatic logic [2:0] ccs_sel(input logic [14:0] p, input int pos);
      return p[pos +: 3];
   endfunction

   // ==========================================================
   // next state
   always_comb
   begin
      logic fail;
      logic adv;
      fail = 1'b0;
      adv = 1'b1;
      st_nxt = st_r;
      st_nxt.clk_sync = {st_r.clk_sync[0], cfg_clk_in};
      st_nxt.clk_prev = st_r.clk_sync[1];
      st_nxt.val_sync = {st_r.val_sync[0], cmd_valid_in};
      st_nxt.auth_sync = {st_r.auth_sync[0], auth_fail_in};
      st_nxt.lock_sync = {st_r.lock_sync[0], clock_gen_locked_in};
      st_nxt.match_sync = {st_r.match_sync[0], impedance_match_in};
      st_nxt.done_sync = {st_r.done_sync[0], done_pin_in};
      st_nxt.prog_sync = {st_r.prog_sync[0], program_pulse_in};
      // stream words pass two flops; the source holds them around the rise
      st_nxt.code_m = cmd_code_in;
      st_nxt.data_m = cmd_data_in;
      st_nxt.code = st_r.code_m;
      st_nxt.data = st_r.data_m;
      st_nxt.fallback = 1'b0;
      st_nxt.frame_we = 1'b0;
      if (rise && st_r.val_sync[1])
      begin
         unique case (st_r.ld)
            LD_IDLE:
            begin
               if (st_r.code == ccs_pkg::CMD_SYNC)
                  st_nxt.ld = LD_SYNCED;
            end
            LD_SYNCED, LD_LOAD:
            begin
               if (st_r.code == ccs_pkg::CMD_DESYNC)
                  st_nxt.ld = LD_IDLE;
               else if (st_r.code == ccs_pkg::CMD_IDCHK)
               begin
                  if (st_r.data == {ccs_pkg::ID_VERSION, ccs_pkg::ID_DEVICE,
                                    ccs_pkg::ID_COMPANY, 1'b1})
                  begin
                     st_nxt.id_ok = 1'b1;
                     st_nxt.ld = LD_LOAD;
                  end
                  else
                  begin
                     st_nxt.id_err = 1'b1;
                     fail = 1'b1;
                  end
               end
               else if (st_r.code == ccs_pkg::CMD_FRAME && st_r.id_ok)
               begin
                  st_nxt.crc = ccs_crc_step(st_r.crc, st_r.data);
                  st_nxt.frame_we = 1'b1;
               end
               else if (st_r.code == ccs_pkg::CMD_CRCCHK && st_r.id_ok)
               begin
                  if (st_r.ctrl[ccs_pkg::CTRL_ENCRYPT])
                  begin
                     if (st_r.auth_sync[1])
                     begin
                        st_nxt.sec_err = 1'b1;
                        fail = 1'b1;
                     end
                  end
                  else if (st_r.ctrl[ccs_pkg::CTRL_CRC_EN] && st_r.data != st_r.crc)
                  begin
                     st_nxt.crc_err = 1'b1;
                     fail = 1'b1;
                  end
               end
               else if (st_r.code == ccs_pkg::CMD_START && st_r.id_ok)
               begin
                  st_nxt.ld = LD_STARTUP;
                  st_nxt.phase = 3'h0;
               end
               else if (st_r.code == ccs_pkg::CMD_WRAP && st_r.ctrl[ccs_pkg::CTRL_FLASH]
                        && st_r.ctrl[ccs_pkg::CTRL_ASYNC_RD])
               begin
                  fail = 1'b1;
               end
            end
            default:
            begin
            end
         endcase
      end
      // desync leaves done low, error high
      if (fail)
      begin
         st_nxt.ld = LD_ABORT;
         st_nxt.err_drive = st_r.ctrl[ccs_pkg::CTRL_ERRPIN_EN] && !st_nxt.sec_err;
         st_nxt.crc = ccs_pkg::CRC_SEED;
         st_nxt.id_ok = 1'b0;
         if (st_r.ctrl[ccs_pkg::CTRL_MASTER] || st_nxt.id_err)
         begin
            if (st_r.fb_tried && st_r.ctrl[ccs_pkg::CTRL_FLASH])
               st_nxt.ld = LD_DEAD;
            else if (!st_r.fb_tried)
            begin
               st_nxt.fallback = 1'b1;
               st_nxt.fb_tried = 1'b1;
               st_nxt.ld = LD_IDLE;
            end
         end
      end
      // start-up sequencer
      if (st_r.ld == LD_STARTUP && rise)
      begin
         if (st_r.ctrl[ccs_pkg::CTRL_LOCK_WAIT] && !st_r.lock_sync[1]
             && st_r.phase == ccs_sel(st_r.phsel, ccs_pkg::PH_LOCK))
            adv = 1'b0;
         if (st_r.ctrl[ccs_pkg::CTRL_MATCH_WAIT] && !st_r.match_sync[1]
             && st_r.phase == ccs_sel(st_r.phsel, ccs_pkg::PH_MATCH))
            adv = 1'b0;
         // release phase holds until pin seen
         if (st_r.phase == ccs_sel(st_r.phsel, ccs_pkg::PH_DONE))
         begin
            st_nxt.released = 1'b1;
            if (!st_r.released)
               adv = 1'b0;
         end
         if (st_r.released && !st_r.done_sync[1])
            adv = 1'b0;
         if (adv && st_r.phase == ccs_sel(st_r.phsel, ccs_pkg::PH_GTS))
            st_nxt.global_tristate = 1'b0;
         if (adv && st_r.phase == ccs_sel(st_r.phsel, ccs_pkg::PH_GWE))
            st_nxt.global_write_enable = 1'b1;
         if (st_r.phase == ccs_pkg::PHASE_LAST)
         begin
            st_nxt.end_of_startup = 1'b1;
            st_nxt.ld = LD_DONE;
         end
         else if (adv)
            st_nxt.phase = st_r.phase + 3'h1;
      end
      // register writes
      if (reg_wr_in && reg_addr_in == ccs_pkg::ADDR_CTRL)
         st_nxt.ctrl = reg_wdata_in[7:0];
      if (reg_wr_in && reg_addr_in == ccs_pkg::ADDR_PHASE)
         st_nxt.phsel = reg_wdata_in[14:0];
      if (st_r.prog_sync[1])
      begin
         st_nxt.ld = LD_IDLE;
         st_nxt.id_ok = 1'b0;
         st_nxt.crc_err = 1'b0;
         st_nxt.id_err = 1'b0;
         st_nxt.sec_err = 1'b0;
         st_nxt.fb_tried = 1'b0;
         st_nxt.err_drive = 1'b0;
         st_nxt.released = 1'b0;
         st_nxt.global_write_enable = 1'b0;
         st_nxt.global_tristate = 1'b1;
         st_nxt.end_of_startup = 1'b0;
         st_nxt.crc = ccs_pkg::CRC_SEED;
      end
      st_nxt.rdata = 32'h00000000;
      if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            ccs_pkg::ADDR_CTRL: st_nxt.rdata = {24'h000000, st_r.ctrl};
            ccs_pkg::ADDR_PHASE: st_nxt.rdata = {17'h00000, st_r.phsel};
            ccs_pkg::ADDR_STATUS:
            begin
               st_nxt.rdata[ccs_pkg::ST_SYNC] = st_r.ld != LD_IDLE;
               st_nxt.rdata[ccs_pkg::ST_ID_OK] = st_r.id_ok;
               st_nxt.rdata[ccs_pkg::ST_CRC_ERR] = st_r.crc_err;
               st_nxt.rdata[ccs_pkg::ST_ID_ERR] = st_r.id_err;
               st_nxt.rdata[ccs_pkg::ST_SEC_ERR] = st_r.sec_err;
               st_nxt.rdata[ccs_pkg::ST_FALLBACK] = st_r.fb_tried;
               st_nxt.rdata[ccs_pkg::ST_DEAD] = st_r.ld == LD_DEAD;
               st_nxt.rdata[ccs_pkg::ST_RELEASED] = st_r.released;
               st_nxt.rdata[ccs_pkg::ST_EOS] = st_r.end_of_startup;
               st_nxt.rdata[ccs_pkg::ST_PHASE +: 3] = st_r.phase;
            end
            ccs_pkg::ADDR_CRC: st_nxt.rdata = st_r.crc;
            ccs_pkg::ADDR_IDCODE: st_nxt.rdata = {ccs_pkg::ID_VERSION, ccs_pkg::ID_DEVICE,
                                                  ccs_pkg::ID_COMPANY, 1'b1};
            default: st_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   assign rise = st_r.clk_sync[1] && !st_r.clk_prev;

   // ==========================================================
   // registers
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         st_r <= '0;
         st_r.ld <= LD_IDLE;
         st_r.ctrl <= ccs_pkg::CTRL_RESET;
         st_r.phsel <= ccs_pkg::PHASE_RESET;
         st_r.global_tristate <= 1'b1;
         st_r.crc <= ccs_pkg::CRC_SEED;
      end
      else
         st_r <= st_nxt;
   end

   // ==========================================================
   // outputs from flip-flops, error enable inverted; pin data tied low
   assign reg_rdata_out = st_r.rdata;
   assign done_pin_out = 1'b0;
   assign done_pin_oe_n_out = st_r.released;
   assign error_pin_out = 1'b0;
   assign error_pin_oe_n_out = !st_r.err_drive;
   assign global_write_enable_out = st_r.global_write_enable;
   assign global_tristate_out = st_r.global_tristate;
   assign end_of_startup_out = st_r.end_of_startup;
   assign fallback_out = st_r.fallback;
   assign frame_we_out = st_r.frame_we;

   // ==========================================================
   // checks
   sequence ccs_start_s;
      st_r.ld == LD_STARTUP && rise;
   endsequence

   frame_gate_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      st_r.frame_we |-> $past(st_r.id_ok))
      else $error("frame loaded before id check");
   phase_step_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $changed(st_r.phase) && st_r.ld == LD_STARTUP && $past(st_r.ld) == LD_STARTUP
      |-> st_r.phase == $past(st_r.phase) + 3'h1)
      else $error("phase skipped");
   eos_last_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(st_r.end_of_startup) |-> $past(st_r.phase) == 3'h7)
      else $error("end of start-up outside last phase");
   done_wait_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ccs_start_s and st_r.released && !st_r.done_sync[1] |=> $stable(st_r.phase))
      else $error("advanced with completion pin low");
   lock_stall_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      ccs_start_s and st_r.ctrl[6] && !st_r.lock_sync[1]
      && st_r.phase == st_r.phsel[2:0] |=> $stable(st_r.phase))
      else $error("lock wait not honoured");
   crc_fail_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(st_r.crc_err) && st_r.ctrl[1] |-> st_r.err_drive && !error_pin_oe_n_out)
      else $error("crc error not signalled");
   gwe_after_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(st_r.global_write_enable) |-> $past(st_r.phase) == st_r.phsel[8:6] && $past(rise))
      else $error("write enable at wrong phase");
   gts_drop_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $fell(st_r.global_tristate) |-> $past(st_r.phase) == st_r.phsel[11:9])
      else $error("tristate released at wrong phase");
endmodule // ccs_top
`default_nettype wire

// ==== dv/ccs_src.sv ====
// bitstream source and board logic on the completion pin
`default_nettype none
module ccs_src
(
   input wire logic oe_n_in,
   input wire logic drv_in,
   input wire logic hold_in,
   output logic clk_out,
   output logic vld_out,
   output logic [2:0] code_out,
   output logic [31:0] data_out,
   output logic done_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // pin level
   // pull-up unless a party pulls low
   assign done_out = !oe_n_in ? drv_in : !hold_in;
   initial
   begin
      clk_out = 1'b0;
      vld_out = 1'b0;
      code_out = 3'h0;
      data_out = 32'h0;
   end
   // ==========
   // word transfer
   // idle words also give start-up clocks
   // 800 ns per word; lines held 300 ns past the rise, return after the
   // block has acted on it
   task automatic word(input logic v, input logic [2:0] c, input logic [31:0] d);
      #25;
      vld_out = v;
      code_out = c;
      data_out = d;
      #350;
      clk_out = 1'b1;
      #300;
      // released lines invert, stale data never repeats
      vld_out = 1'b0;
      code_out = ~c;
      data_out = ~d;
      #100;
      clk_out = 1'b0;
      #25;
   endtask
endmodule // ccs_src
`default_nettype wire

// ==== dv/test_ccs_top.sv ====
// self-checking bench for the config check and start-up sequencer
`default_nettype none
module test_ccs_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] ID_W = {ccs_pkg::ID_VERSION, ccs_pkg::ID_DEVICE,
      ccs_pkg::ID_COMPANY, 1'b1};
   logic clk = 1'b0;
   logic rst, config_clock, vld, auth, lock, match, dlvl, prog, hold, wr, rd;
   logic [2:0] code;
   logic [31:0] data, wdata, rdata, st, crc;
   logic [3:0] addr;
   logic d_drv, d_oe_n, e_drv, e_oe_n, global_write_enable, global_tristate, end_of_startup, fb, fwe, elvl;
   int n_errors, compares, n_fb, n_fw;
   logic [7:0] ctl [4];
   logic [2:0] exp3 [4];
   ccs_top uut
   (
      .ref_clk_in(clk),
      .sys_rst_in(rst),
      .cfg_clk_in(config_clock),
      .cmd_valid_in(vld),
      .cmd_code_in(code),
      .cmd_data_in(data),
      .auth_fail_in(auth),
      .clock_gen_locked_in(lock),
      .impedance_match_in(match),
      .done_pin_in(dlvl),
      .program_pulse_in(prog),
      .reg_addr_in(addr),
      .reg_wdata_in(wdata),
      .reg_wr_in(wr),
      .reg_rd_in(rd),
      .reg_rdata_out(rdata),
      .done_pin_out(d_drv),
      .done_pin_oe_n_out(d_oe_n),
      .error_pin_out(e_drv),
      .error_pin_oe_n_out(e_oe_n),
      .global_write_enable_out(global_write_enable),
      .global_tristate_out(global_tristate),
      .end_of_startup_out(end_of_startup),
      .fallback_out(fb),
      .frame_we_out(fwe)
   );
   ccs_src src
   (
      .oe_n_in(d_oe_n),
      .drv_in(d_drv),
      .hold_in(hold),
      .clk_out(config_clock),
      .vld_out(vld),
      .code_out(code),
      .data_out(data),
      .done_out(dlvl)
   );
   // error pin is open drain with a pull-up
   assign elvl = e_oe_n ? 1'b1 : e_drv;
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      if (fb === 1'b1)
         n_fb++;
      if (fwe === 1'b1)
         n_fw++;
   end
   // ==========
   // helpers
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
      logic [31:0] r;
      r = c ^ d;
      for (int i = 0; i < 32; i++)
         r = r[0] ? (r >> 1) ^ ccs_pkg::CRC_POLY : r >> 1;
      return r;
   endfunction
   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("FAIL %0t mismatch got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      st = rdata;
   endtask
   task automatic st_chk(input int b, input logic e);
      rd_reg(ccs_pkg::ADDR_STATUS);
      chk(32'(st[b]), 32'(e));
   endtask
   task automatic ph_chk(input logic [2:0] e);
      rd_reg(ccs_pkg::ADDR_STATUS);
      chk(32'(st[ccs_pkg::ST_PHASE +: 3]), 32'(e));
   endtask
   task automatic boot(input logic [7:0] c, input logic [14:0] p);
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wr_reg(ccs_pkg::ADDR_CTRL, 32'(c));
      wr_reg(ccs_pkg::ADDR_PHASE, 32'(p));
      n_fb = 0;
      n_fw = 0;
   endtask
   task automatic load(input logic id_ok, input logic crc_ok);
      crc = ccs_pkg::CRC_SEED;
      src.word(1'b1, ccs_pkg::CMD_SYNC, 32'h0);
      src.word(1'b1, ccs_pkg::CMD_IDCHK, id_ok ? ID_W : ~ID_W);
      for (int i = 0; i < 3; i++)
      begin
         src.word(1'b1, ccs_pkg::CMD_FRAME, 32'hA5C30000 + 32'(i));
         crc = crc_step(crc, 32'hA5C30000 + 32'(i));
      end
      src.word(1'b1, ccs_pkg::CMD_CRCCHK, crc_ok ? crc : ~crc);
   endtask
   // idle rises; phase never jumps by more than one
   task automatic run(input int n);
      logic [2:0] prev;
      rd_reg(ccs_pkg::ADDR_STATUS);
      prev = st[ccs_pkg::ST_PHASE +: 3];
      repeat (n)
      begin
         src.word(1'b0, 3'h0, 32'h0);
         rd_reg(ccs_pkg::ADDR_STATUS);
         chk(32'(st[ccs_pkg::ST_PHASE +: 3] - prev <= 3'h1), 32'h1);
         prev = st[ccs_pkg::ST_PHASE +: 3];
      end
   endtask
   initial
   begin
      #5000000;
      n_errors++;
      $display("FAIL %0t timeout", $time);
      end_sim;
   end
   // ==========
   // main sequence
   initial
   begin
      {rst, auth, prog, wr, rd, hold, lock, match} = 8'h83;
      addr = 4'h0;
      wdata = 32'h0;
      ctl = '{8'h0B, 8'h09, 8'h0A, 8'h03};
      exp3 = '{3'h3, 3'h7, 3'h4, 3'h2};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'({d_oe_n, elvl, global_write_enable, global_tristate, end_of_startup}), 32'hA);
      rd_reg(ccs_pkg::ADDR_CTRL);
      chk(st, 32'(ccs_pkg::CTRL_RESET));
      rd_reg(ccs_pkg::ADDR_PHASE);
      chk(st, 32'(ccs_pkg::PHASE_RESET));
      rd_reg(ccs_pkg::ADDR_IDCODE);
      chk(st, ID_W);
      wr_reg(4'hF, 32'hFFFFFFFF);
      rd_reg(4'hF);
      chk(st, 32'h0);
      boot(ccs_pkg::CTRL_RESET, ccs_pkg::PHASE_RESET);
      load(1'b0, 1'b1);
      chk(32'(n_fw), 32'h0);
      chk(32'(n_fb), 32'h1);
      st_chk(ccs_pkg::ST_ID_ERR, 1'b1);
      boot(ccs_pkg::CTRL_RESET, ccs_pkg::PHASE_RESET);
      load(1'b1, 1'b1);
      chk(32'(n_fw), 32'h3);
      rd_reg(ccs_pkg::ADDR_CRC);
      chk(st, crc);
      chk(32'(elvl), 32'h1);
      hold <= 1'b1;
      src.word(1'b1, ccs_pkg::CMD_START, 32'h0);
      run(12);
      ph_chk(3'h4);
      chk(32'({d_oe_n, dlvl, global_tristate, end_of_startup}), 32'hA);
      st_chk(ccs_pkg::ST_RELEASED, 1'b1);
      hold <= 1'b0;
      run(12);
      chk(32'({global_tristate, global_write_enable, end_of_startup}), 32'h3);
      ph_chk(ccs_pkg::PHASE_LAST);
      boot(8'hCB, {3'h3, 3'h4, 3'h5, 3'h1, 3'h2});
      {lock, match} <= 2'b00;
      load(1'b1, 1'b1);
      src.word(1'b1, ccs_pkg::CMD_START, 32'h0);
      run(8);
      ph_chk(3'h1);
      match <= 1'b1;
      run(8);
      ph_chk(3'h2);
      chk(32'({global_write_enable, d_oe_n}), 32'h0);
      lock <= 1'b1;
      run(8);
      chk(32'({global_tristate, global_write_enable, end_of_startup}), 32'h3);
      for (int i = 0; i < 4; i++)
      begin
         boot(ctl[i], ccs_pkg::PHASE_RESET);
         load(1'b1, 1'b0);
         rd_reg(ccs_pkg::ADDR_STATUS);
         chk(32'({elvl, st[ccs_pkg::ST_CRC_ERR], n_fb == 1}), 32'(exp3[i]));
      end
      boot(8'h0F, ccs_pkg::PHASE_RESET);
      auth <= 1'b1;
      load(1'b1, 1'b0);
      st_chk(ccs_pkg::ST_SEC_ERR, 1'b1);
      st_chk(ccs_pkg::ST_CRC_ERR, 1'b0);
      auth <= 1'b0;
      boot(ccs_pkg::CTRL_RESET, ccs_pkg::PHASE_RESET);
      src.word(1'b1, ccs_pkg::CMD_SYNC, 32'h0);
      src.word(1'b1, ccs_pkg::CMD_FRAME, 32'h1);
      src.word(1'b1, ccs_pkg::CMD_IDCHK, ID_W);
      chk(32'(n_fw), 32'h0);
      src.word(1'b1, ccs_pkg::CMD_DESYNC, 32'h0);
      src.word(1'b1, ccs_pkg::CMD_CRCCHK, 32'h1);
      src.word(1'b1, ccs_pkg::CMD_START, 32'h0);
      run(8);
      chk(32'({elvl, dlvl, end_of_startup}), 32'h4);
      for (int i = 0; i < 2; i++)
      begin
         boot(i ? 8'h1B : 8'h3B, ccs_pkg::PHASE_RESET);
         src.word(1'b1, ccs_pkg::CMD_SYNC, 32'h0);
         src.word(1'b1, ccs_pkg::CMD_WRAP, 32'h0);
         chk(32'(n_fb), 32'(i == 0));
      end
      boot(8'h1B, ccs_pkg::PHASE_RESET);
      load(1'b1, 1'b0);
      load(1'b1, 1'b0);
      st_chk(ccs_pkg::ST_DEAD, 1'b1);
      n_fw = 0;
      load(1'b1, 1'b1);
      chk(32'(n_fw), 32'h0);
      prog <= 1'b1;
      repeat (4) @(posedge clk);
      prog <= 1'b0;
      repeat (4) @(posedge clk);
      st_chk(ccs_pkg::ST_DEAD, 1'b0);
      n_fw = 0;
      load(1'b1, 1'b1);
      chk(32'(n_fw), 32'h3);
      end_sim;
   end
endmodule // test_ccs_top
`default_nettype wire
